// ==== design/bridge_pkg.sv ====
// Shared constants for the modem FIFO bridge
package bridge_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_TX_DATA    = 8'h00;
   localparam logic [7:0] ADDR_RX_DATA    = 8'h04;
   localparam logic [7:0] ADDR_FIFO_CTRL  = 8'h08;
   localparam logic [7:0] ADDR_TX_OCC     = 8'h0c;
   localparam logic [7:0] ADDR_RX_OCC     = 8'h10;
   localparam logic [7:0] ADDR_EVT_FLAGS  = 8'h14;
   localparam logic [7:0] ADDR_EVT_MASK   = 8'h18;
   localparam logic [7:0] ADDR_SETUP      = 8'h1c;
   localparam logic [7:0] ADDR_CONTROL    = 8'h20;
   localparam logic [7:0] ADDR_PIN_CFG    = 8'h24;
   localparam logic [7:0] ADDR_GLB_ALERT  = 8'h28;
   // Field layout
   localparam int TXTH_LSB   = 0;
   localparam int RXTH_LSB   = 8;
   localparam int TH_W       = 6;
   localparam int EV_TXLVL   = 0;
   localparam int EV_RXLVL   = 1;
   localparam int EV_FRAME   = 2;
   localparam int EV_OVRRUN  = 3;
   localparam int EV_W       = 4;
   localparam int SU_POWER   = 0;
   localparam int SU_DUPLEX  = 1;
   localparam int CTL_RTS    = 0;
   localparam int GA_MODEM   = 0;
   localparam int GA_RESET   = 1;
   // Pin function select codes
   localparam logic [1:0] PIN_OFF     = 2'h0;
   localparam logic [1:0] PIN_OBS_TX  = 2'h1;
   localparam logic [1:0] PIN_OBS_RX  = 2'h2;
   localparam logic [1:0] PIN_DRV_RX  = 2'h3;
   // Reset values
   localparam logic [5:0] TXTH_RST = 6'h04;
   localparam logic [5:0] RXTH_RST = 6'h1c;
   // Serial timing: one bit every BIT_CYCLES clocks
   localparam int BAUD      = 1200;
   localparam int CLK_HZ    = 10_000_000;
   localparam int BIT_CYCLES = CLK_HZ / BAUD;
   localparam int FRAME_BITS = 10;
endpackage

// ==== design/byte_fifo_if.sv ====
// Push and pop signals of one byte FIFO
`timescale 1ns/100ps
interface byte_fifo_if #(parameter int DW = 8, parameter int CW = 6);
   logic          push;
   logic [DW-1:0] wdata;
   logic          pop;
   logic [DW-1:0] rdata;
   logic [CW-1:0] count;
   logic          full;
   logic          empty;
   modport fifo (input push, wdata, pop, output rdata, count, full, empty);
   modport user (output push, wdata, pop, input rdata, count, full, empty);
endinterface

// ==== design/byte_fifo.sv ====
// Flip-flop byte FIFO with occupancy count
`timescale 1ns/100ps
module byte_fifo #(
   parameter int DEPTH = 32,
   parameter int DW    = 8,
   parameter int CW    = 6
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // FIFO port
   byte_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   logic [DW-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [CW-1:0] cnt_ff;
   logic          do_push;
   logic          do_pop;

   // Refuse push when full and pop when empty
   assign do_push = f.push && !f.full;
   assign do_pop  = f.pop && !f.empty;
   assign f.full  = (cnt_ff == CW'(DEPTH));
   assign f.empty = (cnt_ff == '0);
   assign f.count = cnt_ff;
   assign f.rdata = f.empty ? '0 : mem_ff[rptr_ff];

   // Storage write
   always_ff @(posedge clk) begin
      if (ce && do_push) begin
         mem_ff[wptr_ff] <= f.wdata;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff  <= '0;
      end else if (ce) begin
         if (do_push) begin
            wptr_ff <= (wptr_ff == AW'(DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
         end
         if (do_pop) begin
            rptr_ff <= (rptr_ff == AW'(DEPTH - 1)) ? '0 : rptr_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
      end
   end
endmodule

// ==== design/modem_spi_uart_fifo_bridge.sv ====
// Register bridge between APB and the modem UART with two byte FIFOs
`timescale 1ns/100ps
module modem_spi_uart_fifo_bridge #(
   parameter int DEPTH      = 32,
   parameter int BIT_CYCLES = bridge_pkg::BIT_CYCLES
) (
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Modem UART lines
   output logic             modem_txd,
   input  wire logic        modem_rxd,
   // General-purpose pin
   input  wire logic        gp_pin_in,
   output logic             gp_pin_out,
   output logic             gp_pin_oe,
   // Alert pin, active low
   output logic             alert_n
);
   localparam int CW = $clog2(DEPTH) + 1;
   localparam int BCW = $clog2(BIT_CYCLES + 1);

   byte_fifo_if #(.DW(8), .CW(CW)) txf ();
   byte_fifo_if #(.DW(8), .CW(CW)) rxf ();

   byte_fifo #(.DEPTH(DEPTH), .DW(8), .CW(CW)) u_tx_fifo (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (clk_en),
      .f     (txf.fifo)
   );
   byte_fifo #(.DEPTH(DEPTH), .DW(8), .CW(CW)) u_rx_fifo (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (clk_en),
      .f     (rxf.fifo)
   );

   //----------------------------------------------------------------
   // Register file
   //----------------------------------------------------------------
   localparam int EVW = bridge_pkg::EV_W;
   logic [5:0]      tx_level_threshold_ff;
   logic [5:0]      rx_level_threshold_ff;
   logic [EVW-1:0]  modem_event_flags_ff;
   logic [EVW-1:0]  modem_event_mask_ff;
   logic [1:0]      modem_setup_ff;
   logic            modem_control_ff;
   logic [1:0]      pin_function_config_ff;
   logic            reset_occurred_ff;
   logic            rx_pop_ok_ff;
   logic            wr_acc;
   logic            rd_acc;
   logic            addr_ok;
   logic [EVW-1:0]  ev_set;
   logic            modem_event_summary;

   // Access phase strobes, slave always ready
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   always_comb begin
      case (paddr)
         bridge_pkg::ADDR_TX_DATA, bridge_pkg::ADDR_RX_DATA,
         bridge_pkg::ADDR_FIFO_CTRL, bridge_pkg::ADDR_TX_OCC,
         bridge_pkg::ADDR_RX_OCC, bridge_pkg::ADDR_EVT_FLAGS,
         bridge_pkg::ADDR_EVT_MASK, bridge_pkg::ADDR_SETUP,
         bridge_pkg::ADDR_CONTROL, bridge_pkg::ADDR_PIN_CFG,
         bridge_pkg::ADDR_GLB_ALERT: addr_ok = 1'b1;
         default:                    addr_ok = 1'b0;
      endcase
   end

   // Push on data write, dropped when full
   assign txf.push  = clk_en && wr_acc && (paddr == bridge_pkg::ADDR_TX_DATA);
   assign txf.wdata = pwdata[7:0];

   // Plain control registers
   // Separate threshold fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_level_threshold_ff  <= bridge_pkg::TXTH_RST;
         rx_level_threshold_ff  <= bridge_pkg::RXTH_RST;
         modem_event_mask_ff    <= '0;
         modem_setup_ff         <= '0;
         modem_control_ff       <= 1'b0;
         pin_function_config_ff <= bridge_pkg::PIN_OFF;
      end else if (clk_en && wr_acc) begin
         case (paddr)
            bridge_pkg::ADDR_FIFO_CTRL: begin
               tx_level_threshold_ff <= pwdata[bridge_pkg::TXTH_LSB +: 6];
               rx_level_threshold_ff <= pwdata[bridge_pkg::RXTH_LSB +: 6];
            end
            bridge_pkg::ADDR_EVT_MASK: modem_event_mask_ff <= pwdata[EVW-1:0];
            bridge_pkg::ADDR_SETUP:    modem_setup_ff <= pwdata[1:0];
            bridge_pkg::ADDR_CONTROL:  modem_control_ff <= pwdata[bridge_pkg::CTL_RTS];
            bridge_pkg::ADDR_PIN_CFG:  pin_function_config_ff <= pwdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // Event flags: set wins over write-one-to-clear
   // Flags record regardless of mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_event_flags_ff <= '0;
      end else if (clk_en) begin
         if (wr_acc && paddr == bridge_pkg::ADDR_EVT_FLAGS) begin
            modem_event_flags_ff <= (modem_event_flags_ff & ~pwdata[EVW-1:0]) | ev_set;
         end else begin
            modem_event_flags_ff <= modem_event_flags_ff | ev_set;
         end
      end
   end

   // Reset flag set at power-up, cleared by one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_occurred_ff <= 1'b1;
      end else if (clk_en && wr_acc && paddr == bridge_pkg::ADDR_GLB_ALERT
                   && pwdata[bridge_pkg::GA_RESET]) begin
         reset_occurred_ff <= 1'b0;
      end
   end

   // Summary of any modem flag, masked or not
   assign modem_event_summary = |modem_event_flags_ff;

   // Alert pin from unmasked flags and reset flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_n <= 1'b0;
      end else if (clk_en) begin
         alert_n <= !(reset_occurred_ff || |(modem_event_flags_ff & ~modem_event_mask_ff));
      end
   end

   // Pop only a byte that the setup cycle returned
   assign rxf.pop = clk_en && rd_acc && (paddr == bridge_pkg::ADDR_RX_DATA) && rx_pop_ok_ff;

   // Read mux, registered
   // Occupancy readback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         rx_pop_ok_ff <= 1'b0;
      end else if (clk_en) begin
         // A byte arriving after setup must not be popped unseen
         rx_pop_ok_ff <= psel && !penable && !pwrite && (paddr == bridge_pkg::ADDR_RX_DATA)
                         && !rxf.empty;
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               bridge_pkg::ADDR_RX_DATA:   prdata <= {24'h000000, rxf.rdata};
               bridge_pkg::ADDR_FIFO_CTRL: prdata <= {18'h00000, rx_level_threshold_ff,
                                                      2'h0, tx_level_threshold_ff};
               bridge_pkg::ADDR_TX_OCC:    prdata <= 32'(txf.count);
               bridge_pkg::ADDR_RX_OCC:    prdata <= 32'(rxf.count);
               bridge_pkg::ADDR_EVT_FLAGS: prdata <= 32'(modem_event_flags_ff);
               bridge_pkg::ADDR_EVT_MASK:  prdata <= 32'(modem_event_mask_ff);
               bridge_pkg::ADDR_SETUP:     prdata <= 32'(modem_setup_ff);
               bridge_pkg::ADDR_CONTROL:   prdata <= 32'(modem_control_ff);
               bridge_pkg::ADDR_PIN_CFG:   prdata <= 32'(pin_function_config_ff);
               bridge_pkg::ADDR_GLB_ALERT: prdata <= {30'h0, reset_occurred_ff,
                                                      modem_event_summary};
               default:                    prdata <= '0;
            endcase
         end
      end
   end

   //----------------------------------------------------------------
   // Level alerts
   //----------------------------------------------------------------
   logic tx_low;
   logic rx_high;
   assign tx_low  = txf.count < CW'(tx_level_threshold_ff);
   assign rx_high = rxf.count > CW'(rx_level_threshold_ff);

   //----------------------------------------------------------------
   // Serial transmitter
   //----------------------------------------------------------------
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} tx_state_t;
   tx_state_t   tx_st_ff;
   logic [9:0]  tx_sh_ff;
   logic [3:0]  tx_bits_ff;
   logic [BCW-1:0] tx_tick_ff;
   logic        txd_int;
   logic        tx_go;

   // Start when RTS set and modem powered
   assign tx_go    = modem_control_ff && modem_setup_ff[bridge_pkg::SU_POWER] && !txf.empty;
   assign txf.pop  = clk_en && (tx_st_ff == TX_IDLE) && tx_go;
   assign txd_int  = (tx_st_ff == TX_SHIFT) ? tx_sh_ff[0] : 1'b1;

   // Byte framed as start, eight data, stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_ff   <= TX_IDLE;
         tx_sh_ff   <= '1;
         tx_bits_ff <= '0;
         tx_tick_ff <= '0;
      end else if (clk_en) begin
         case (tx_st_ff)
            TX_IDLE: begin
               if (tx_go) begin
                  tx_sh_ff   <= {1'b1, txf.rdata, 1'b0};
                  tx_bits_ff <= '0;
                  tx_tick_ff <= '0;
                  tx_st_ff   <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tx_tick_ff == BCW'(BIT_CYCLES - 1)) begin
                  tx_tick_ff <= '0;
                  tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
                  tx_bits_ff <= tx_bits_ff + 1'b1;
                  if (tx_bits_ff == 4'(bridge_pkg::FRAME_BITS - 1)) begin
                     tx_st_ff <= TX_IDLE;
                  end
               end else begin
                  tx_tick_ff <= tx_tick_ff + 1'b1;
               end
            end
            default: tx_st_ff <= TX_IDLE;
         endcase
      end
   end

   //----------------------------------------------------------------
   // Receive input selection and synchroniser
   //----------------------------------------------------------------
   logic [1:0] rxd_sync_ff;
   logic [1:0] gp_sync_ff;
   logic       rxd_src;
   // Two-stage synchronisers for pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_sync_ff <= 2'b11;
         gp_sync_ff  <= 2'b11;
      end else if (clk_en) begin
         rxd_sync_ff <= {rxd_sync_ff[0], modem_rxd};
         gp_sync_ff  <= {gp_sync_ff[0], gp_pin_in};
      end
   end

   // Duplex loops transmit; pin may drive receive
   always_comb begin
      if (modem_setup_ff[bridge_pkg::SU_DUPLEX]) begin
         rxd_src = txd_int;
      end else if (pin_function_config_ff == bridge_pkg::PIN_DRV_RX) begin
         rxd_src = gp_sync_ff[1];
      end else begin
         rxd_src = rxd_sync_ff[1];
      end
   end

   //----------------------------------------------------------------
   // Serial receiver
   //----------------------------------------------------------------
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SHIFT = 2'b01} rx_state_t;
   rx_state_t   rx_st_ff;
   logic [8:0]  rx_sh_ff;
   logic [3:0]  rx_bits_ff;
   logic [BCW-1:0] rx_tick_ff;
   logic        rx_done;
   logic        rx_on;

   assign rx_on   = modem_setup_ff[bridge_pkg::SU_POWER];
   assign rx_done = (rx_st_ff == RX_SHIFT) && (rx_tick_ff == BCW'(BIT_CYCLES - 1))
                    && (rx_bits_ff == 4'(bridge_pkg::FRAME_BITS - 1));
   assign rxf.push  = clk_en && rx_done && rxd_src && !rxf.full;
   assign rxf.wdata = rx_sh_ff[8:1];

   // Sample each bit mid-period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_ff   <= RX_IDLE;
         rx_sh_ff   <= '0;
         rx_bits_ff <= '0;
         rx_tick_ff <= '0;
      end else if (clk_en) begin
         case (rx_st_ff)
            RX_IDLE: begin
               if (rx_on && !rxd_src) begin
                  rx_tick_ff <= BCW'(BIT_CYCLES / 2);
                  rx_bits_ff <= '0;
                  rx_st_ff   <= RX_SHIFT;
               end
            end
            RX_SHIFT: begin
               if (rx_tick_ff == BCW'(BIT_CYCLES - 1)) begin
                  rx_tick_ff <= '0;
                  rx_bits_ff <= rx_bits_ff + 1'b1;
                  if (rx_bits_ff != 4'(bridge_pkg::FRAME_BITS - 1)) begin
                     rx_sh_ff <= {rxd_src, rx_sh_ff[8:1]};
                  end else begin
                     rx_st_ff <= RX_IDLE;
                  end
               end else begin
                  rx_tick_ff <= rx_tick_ff + 1'b1;
               end
            end
            default: rx_st_ff <= RX_IDLE;
         endcase
      end
   end

   // Event sources
   assign ev_set = {rx_done && rxd_src && rxf.full, rx_done && !rxd_src, rx_high, tx_low};

   //----------------------------------------------------------------
   // Output pins
   //----------------------------------------------------------------
   // Pin observes transmit or receive line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_txd  <= 1'b1;
         gp_pin_out <= 1'b0;
         gp_pin_oe  <= 1'b0;
      end else if (clk_en) begin
         modem_txd  <= txd_int;
         gp_pin_out <= (pin_function_config_ff == bridge_pkg::PIN_OBS_TX) ? txd_int
                                                                          : rxd_src;
         gp_pin_oe  <= (pin_function_config_ff == bridge_pkg::PIN_OBS_TX) ||
                       (pin_function_config_ff == bridge_pkg::PIN_OBS_RX);
      end
   end

   //----------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   full_drop_a: assert property (txf.push && txf.full && !txf.pop |=> $stable(txf.count))
      else $error("write to full transmit FIFO changed count");
   empty_read_a: assert property (rd_acc && paddr == bridge_pkg::ADDR_RX_DATA && rxf.empty
      && clk_en |-> prdata == 32'h00000000)
      else $error("empty receive read not zero");
   tx_push_a: assert property (txf.push && !txf.full && !txf.pop
      |=> txf.count == $past(txf.count) + 1'b1)
      else $error("transmit push not counted");
   rx_pop_a: assert property (rxf.pop && !rxf.empty && !rxf.push
      |=> rxf.count == $past(rxf.count) - 1'b1)
      else $error("receive pop not counted");
   tx_level_a: assert property (clk_en && tx_low |=> modem_event_flags_ff[bridge_pkg::EV_TXLVL])
      else $error("transmit level flag missing");
   rx_level_a: assert property (clk_en && rx_high |=> modem_event_flags_ff[bridge_pkg::EV_RXLVL])
      else $error("receive level flag missing");
   alert_pin_a: assert property (clk_en && reset_occurred_ff |=> !alert_n)
      else $error("alert pin not low with reset flag");
   masked_a: assert property (clk_en && !reset_occurred_ff && (modem_event_flags_ff & ~modem_event_mask_ff) == '0
      |=> alert_n)
      else $error("masked flag drove alert pin");
   rts_start_a: assert property (clk_en && tx_st_ff == TX_IDLE && tx_go |=> tx_st_ff == TX_SHIFT)
      else $error("transmit did not start");
   fifo_bound_a: assert property (txf.count <= CW'(DEPTH) && rxf.count <= CW'(DEPTH))
      else $error("FIFO count beyond depth");
endmodule

// ==== tb/modem_model.sv ====
// Far-end modem model: serial receiver and sender on the UART lines
`timescale 1ns/100ps
module modem_model #(
   parameter int BITC = 8
) (
   // Clock and lines
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   byte got[$];
   byte b;
   // Idle line rests at the mark level
   initial rxd = 1'b1;
   initial forever begin
      @(negedge txd);
      repeat (BITC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BITC) @(posedge clk);
         b[i] = txd;
      end
      repeat (BITC) @(posedge clk);
      got.push_back(b);
   end
   // Send one 8N1 frame on the receive line
   task automatic send(input byte v);
      rxd <= 1'b0;
      repeat (BITC) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rxd <= v[i];
         repeat (BITC) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (BITC) @(posedge clk);
   endtask
endmodule

// ==== tb/test_modem_spi_uart_fifo_bridge.sv ====
// Self-checking bench for the modem FIFO bridge
`timescale 1ns/100ps
module test_modem_spi_uart_fifo_bridge;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic        pready, pslverr, modem_txd, modem_rxd, gp_pin_out, gp_pin_oe, alert_n;
   logic        gp_in = 1'b1;
   int          error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'h217338b8;
   byte         q[$], b;
   always #50 pclk = ~pclk;
   modem_spi_uart_fifo_bridge #(.BIT_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn),
      .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .modem_txd(modem_txd), .modem_rxd(modem_rxd), .gp_pin_in(gp_in),
      .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe), .alert_n(alert_n));
   modem_model #(.BITC(8)) far (.clk(pclk), .txd(modem_txd), .rxd(modem_rxd));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("alert_n at reset", alert_n, 0);
      apb(0, bridge_pkg::ADDR_GLB_ALERT, 0);
      chk("reset flag", rd & 32'h2, 32'h2);
      apb(1, bridge_pkg::ADDR_EVT_MASK, 32'hf);
      apb(1, bridge_pkg::ADDR_GLB_ALERT, 32'h0);
      apb(0, bridge_pkg::ADDR_GLB_ALERT, 0);
      chk("zero write keeps", rd & 32'h2, 32'h2);
      apb(1, bridge_pkg::ADDR_GLB_ALERT, 32'h2);
      repeat (3) @(posedge pclk);
      chk("alert_n cleared", alert_n, 1);
      apb(0, bridge_pkg::ADDR_FIFO_CTRL, 0);
      chk("threshold reset", rd, 32'h1c04);
      apb(1, bridge_pkg::ADDR_FIFO_CTRL, 32'h0510);
      apb(0, bridge_pkg::ADDR_FIFO_CTRL, 0);
      chk("threshold write", rd, 32'h0510);
      apb(0, 8'h3c, 0);
      chk("unmapped err", err, 1);
      apb(0, bridge_pkg::ADDR_RX_DATA, 0);
      chk("empty rx read", rd, 0);
      apb(0, bridge_pkg::ADDR_RX_OCC, 0);
      chk("empty rx count", rd, 0);
      $display("register test done");
      // Settle 200 us; no current output, so no slew
      repeat (2000) @(posedge pclk);
      // Power the modem, then fill transmit FIFO past full
      apb(1, bridge_pkg::ADDR_SETUP, 32'h1);
      for (int i = 0; i < 33; i++) begin
         b = $random(seed);
         if (i < 32) q.push_back(b);
         apb(1, bridge_pkg::ADDR_TX_DATA, {24'h0, b});
      end
      apb(0, bridge_pkg::ADDR_TX_OCC, 0);
      chk("tx full count", rd, 32);
      apb(1, bridge_pkg::ADDR_EVT_FLAGS, 32'hf);
      apb(0, bridge_pkg::ADDR_EVT_FLAGS, 0);
      chk("no tx low when full", rd[0], 0);
      apb(1, bridge_pkg::ADDR_CONTROL, 32'h1);
      while (far.got.size() < 32) @(posedge pclk);
      for (int i = 0; i < 32; i++) chk("tx byte", far.got[i], q[i]);
      apb(0, bridge_pkg::ADDR_TX_OCC, 0);
      chk("tx drained count", rd, 0);
      apb(0, bridge_pkg::ADDR_EVT_FLAGS, 0);
      chk("tx low flag", rd[0], 1);
      apb(0, bridge_pkg::ADDR_GLB_ALERT, 0);
      chk("summary flag", rd[0], 1);
      chk("masked pin", alert_n, 1);
      apb(1, bridge_pkg::ADDR_EVT_MASK, 32'h0);
      repeat (3) @(posedge pclk);
      chk("unmasked pin", alert_n, 0);
      $display("transmit test done");
      // Receive 33 frames into a 32-byte FIFO
      q = {};
      apb(1, bridge_pkg::ADDR_EVT_FLAGS, 32'hf);
      for (int i = 0; i < 33; i++) begin
         b = $random(seed);
         if (i < 32) q.push_back(b);
         far.send(b);
      end
      repeat (4) @(posedge pclk);
      apb(0, bridge_pkg::ADDR_RX_OCC, 0);
      chk("rx full count", rd, 32);
      apb(0, bridge_pkg::ADDR_EVT_FLAGS, 0);
      chk("rx high flag", rd[1], 1);
      for (int i = 0; i < 32; i++) begin
         apb(0, bridge_pkg::ADDR_RX_DATA, 0);
         chk("rx byte", rd, {24'h0, q[i]});
      end
      $display("receive test done");
      // Duplex loopback with the pin watching transmit
      apb(1, bridge_pkg::ADDR_SETUP, 32'h3);
      apb(1, bridge_pkg::ADDR_PIN_CFG, {30'h0, bridge_pkg::PIN_OBS_TX});
      repeat (2) @(posedge pclk);
      chk("pin oe", gp_pin_oe, 1);
      chk("pin level", gp_pin_out, 1);
      q = {};
      for (int i = 0; i < 2; i++) begin
         b = $random(seed);
         q.push_back(b);
         apb(1, bridge_pkg::ADDR_TX_DATA, {24'h0, b});
      end
      while (far.got.size() < 34) @(posedge pclk);
      repeat (20) @(posedge pclk);
      for (int i = 0; i < 2; i++) begin
         apb(0, bridge_pkg::ADDR_RX_DATA, 0);
         chk("loop byte", rd, {24'h0, q[i]});
      end
      // Pin drives receive: a frame on the modem line is ignored
      apb(1, bridge_pkg::ADDR_SETUP, 32'h1);
      apb(1, bridge_pkg::ADDR_PIN_CFG, {30'h0, bridge_pkg::PIN_DRV_RX});
      b = $random(seed);
      far.send(b);
      repeat (4) @(posedge pclk);
      chk("pin drive oe", gp_pin_oe, 0);
      apb(0, bridge_pkg::ADDR_RX_OCC, 0);
      chk("pin drive count", rd, 0);
      $display("duplex test done");
      wrap_up();
   end
endmodule
